// >>> dv/rsc_pin_drv.sv
// partner model: supervisor that pulls the external reset pin low
`timescale 1ns/1ns
module rsc_pin_drv (
    // clock
    input wire logic pclk,
    // reset pin
    output logic ext_reset_pin
);
    // released pin sits at the weak pull-up level, never floats
    initial begin
        ext_reset_pin = 1'b1;
    end
    // hold the pin low for n cycles; changes only just after an edge
    task automatic pin_low(input int n);
        @(posedge pclk);
        ext_reset_pin <= 1'b0;
        repeat (n) @(posedge pclk);
        ext_reset_pin <= 1'b1;
    endtask
endmodule

// >>> dv/rsc_tb.sv
// self-checking testbench for the reset source and cause block
`timescale 1ns/1ns
module testbench;
    import rsc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, in_sleep, pready, pslverr;
    logic core_reset, pin_pullup_en, pin_gpio_in, ext_reset_pin;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic err;
    logic [20:0] pc_load;
    rsc_src_type src;
    int n_errors = 0;
    int cmp_count = 0;
    // short timer lengths keep the power-up cases brief
    rsc_core #(.POWER_UP_DELAY_TIMER_1(20), .POWER_UP_DELAY_TIMER_2(40), .POWER_UP_DELAY_TIMER_3(60), .OST_LEN(16)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .src(src), .in_sleep(in_sleep),
        .ext_reset_pin(ext_reset_pin), .core_reset(core_reset), .pc_load(pc_load),
        .pin_pullup_en(pin_pullup_en), .pin_gpio_in(pin_gpio_in));
    rsc_pin_drv drv (.pclk(pclk), .ext_reset_pin(ext_reset_pin));
    ////////////////////////////////////////////////////////////////////////////
    // clock; the time-zero input values are set in the run block at the end
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // apb cycle: setup, then access held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        chk("pready", 32'(pready), 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask
    // bounded wait for the held-in-reset output to reach a level
    task automatic wait_rst(input logic lvl, input int max);
        int n;
        n = 0;
        while (core_reset !== lvl && n < max) begin
            @(negedge pclk);
            n++;
        end
        chk("core_reset", core_reset, lvl);
    endtask
    task automatic pulse(input logic [8:0] v);
        @(posedge pclk);
        src <= rsc_src_type'(v);
        @(posedge pclk);
        src <= '0;
    endtask
    // firmware puts every cause register flag back to its inactive state
    task automatic restore();
        wr(CAUSE0_OFF, 32'h3f);
        wr(CAUSE1_OFF, 32'h02);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        rchk("cause0", CAUSE0_OFF, 32'h3c);
        rchk("cause1", CAUSE1_OFF, 32'h02);
        rchk("status", STATUS_OFF, 32'h60);
        chk("pc_load", 32'(pc_load), 32'h0);
        rchk("unmapped", 8'h18, 32'h0);
        chk("pslverr", 32'(err), 32'h1);
        wr(CMD_OFF, 32'ha5);
        chk("pslverr", 32'(err), 32'h0);
        rchk("scratch", CMD_OFF, 32'ha5);
        // power hold done, synced pin high, sequencer running
        rchk("seq", SEQ_OFF, 32'h4);
        $display("test reset values done");
    endtask
    task automatic t_sources();
        logic [8:0] sv[6] = '{9'h010, 9'h008, 9'h004, 9'h002, 9'h001, 9'h020};
        logic [7:0] c0[6] = '{8'h1f, 8'h3b, 8'hbf, 8'h7f, 8'h3f, 8'h2f};
        logic [7:0] c1[6] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h00, 8'h02};
        logic [7:0] st[6] = '{8'h60, 8'h60, 8'h60, 8'h60, 8'h60, 8'h20};
        wr(CONFIG_OFF, 32'h06);
        for (int i = 0; i < 6; i++) begin
            restore();
            pulse(sv[i]);
            wait_rst(1'b1, 20);
            wait_rst(1'b0, 100);
            chk("pc_load", 32'(pc_load), 32'h0);
            rchk("cause0", CAUSE0_OFF, 32'(c0[i]));
            rchk("cause1", CAUSE1_OFF, 32'(c1[i]));
            rchk("status", STATUS_OFF, 32'(st[i]));
        end
        // overflow with stack reset disabled must be ignored
        wr(CONFIG_OFF, 32'h02);
        restore();
        pulse(9'h004);
        repeat (30) @(negedge pclk);
        chk("core_reset", 32'(core_reset), 32'h0);
        rchk("cause0", CAUSE0_OFF, 32'h3f);
        $display("test reset sources done");
    endtask
    task automatic t_pin();
        in_sleep <= 1'b1;
        restore();
        drv.pin_low(4);
        repeat (20) @(negedge pclk);
        chk("core_reset", 32'(core_reset), 32'h0);
        rchk("cause0", CAUSE0_OFF, 32'h3f);
        fork
            drv.pin_low(40);
            begin
                repeat (30) @(negedge pclk);
                chk("core_reset", 32'(core_reset), 32'h1);
            end
        join
        repeat (9) @(negedge pclk);
        chk("core_reset", 32'(core_reset), 32'h1);
        wait_rst(1'b0, 40);
        rchk("cause0", CAUSE0_OFF, 32'h37);
        rchk("status", STATUS_OFF, 32'h40);
        in_sleep <= 1'b0;
        $display("test reset pin done");
    endtask
    task automatic t_pin_cfg();
        logic [7:0] cfg[3] = '{8'h00, 8'h01, 8'h20};
        logic en[3] = '{1'b0, 1'b1, 1'b0};
        logic pu[3] = '{1'b0, 1'b1, 1'b1};
        for (int i = 0; i < 3; i++) begin
            wr(CONFIG_OFF, 32'(cfg[i]));
            fork
                drv.pin_low(30);
                begin
                    repeat (25) @(negedge pclk);
                    chk("core_reset", 32'(core_reset), 32'(en[i]));
                    chk("pin_pullup_en", 32'(pin_pullup_en), 32'(pu[i]));
                    chk("pin_gpio_in", 32'(pin_gpio_in), 32'h0);
                end
            join
            // released pin needs the filter and the synchroniser before it shows
            repeat (15) @(negedge pclk);
            chk("pin_gpio_in", 32'(pin_gpio_in), 32'(!en[i]));
            wait_rst(1'b0, 60);
        end
        wr(CONFIG_OFF, 32'h02);
        $display("test pin config done");
    endtask
    task automatic t_power();
        logic [8:0] sv[4] = '{9'h100, 9'h080, 9'h040, 9'h100};
        logic [7:0] c0[4] = '{8'h3c, 8'h3e, 8'h3c, 8'h3c};
        // each delay select in turn, the last with the oscillator timer only
        logic [7:0] cf[4] = '{8'h42, 8'h82, 8'hc2, 8'h12};
        int hold[4] = '{20, 40, 60, 16};
        int n;
        for (int i = 0; i < 4; i++) begin
            restore();
            wr(CAUSE1_OFF, 32'h00);
            wr(CONFIG_OFF, 32'(cf[i]));
            pulse(sv[i]);
            wait_rst(1'b1, 20);
            n = 0;
            while (core_reset === 1'b1 && n < 200) begin
                @(negedge pclk);
                n++;
            end
            // timer, one cycle to see it end, one to leave hold, then the release count
            chk("hold_cycles", 32'(n), 32'(hold[i] + 2 + RELEASE_OSC_CYCLES));
            rchk("cause0", CAUSE0_OFF, 32'(c0[i]));
            rchk("cause1", CAUSE1_OFF, 32'h02);
            rchk("status", STATUS_OFF, 32'h60);
        end
        // pin kept low past the timers: start waits for its release
        fork
            drv.pin_low(100);
            begin
                repeat (5) @(posedge pclk);
                pulse(9'h100);
            end
        join
        repeat (9) @(negedge pclk);
        chk("core_reset", 32'(core_reset), 32'h1);
        // filter, synchroniser, one cycle to leave hold, then the release count
        repeat (FILT_CYC + 2 + RELEASE_OSC_CYCLES - 8) @(negedge pclk);
        chk("core_reset", 32'(core_reset), 32'h1);
        @(negedge pclk);
        chk("core_reset", 32'(core_reset), 32'h0);
        wait_rst(1'b0, 40);
        $display("test power-up done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // verdict and run control
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // watchdog: the whole run needs about a thousand cycles, the limit is 30000
    initial begin
        #300000;
        n_errors++;
        end_sim();
    end
    initial begin
        {presetn, psel, penable, pwrite, in_sleep} = '0;
        paddr = '0;
        pwdata = '0;
        src = '0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        wait_rst(1'b0, 100);
        t_reset();
        t_sources();
        t_pin();
        t_pin_cfg();
        t_power();
        end_sim();
    end
endmodule

// >>> logic/rsc_core.sv
// reset source sequencing and reset cause registers behind an apb slave
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ns

module rsc_core #(
    parameter int POWER_UP_DELAY_TIMER_1 = rsc_pkg::POWER_UP_DELAY_TIMER_1_CYC,
    parameter int POWER_UP_DELAY_TIMER_2 = rsc_pkg::POWER_UP_DELAY_TIMER_2_CYC,
    parameter int POWER_UP_DELAY_TIMER_3 = rsc_pkg::POWER_UP_DELAY_TIMER_3_CYC,
    parameter int OST_LEN = rsc_pkg::OST_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // reset sources
    input wire rsc_pkg::rsc_src_type src,
    input wire logic in_sleep,
    input wire logic ext_reset_pin,
    // outputs
    output logic core_reset,
    output logic [20:0] pc_load,
    output logic pin_pullup_en,
    output logic pin_gpio_in
);
    import rsc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] cause0_reg, cause1_reg, status_reg, config_reg, cmd_reg;
    logic [2:0] filt_cnt_reg;
    logic pin_filt_reg, pin_s1_reg, pin_s2_reg;
    logic pin_en;
    logic pin_low_evt;
    logic power_evt;
    logic run_evt;
    rsc_seq_type seq_reg;
    logic [31:0] power_up_delay_timer_cnt_reg, ost_cnt_reg, power_up_delay_timer_len;
    logic [3:0] rel_cnt_reg;
    logic power_hold_reg;
    logic wr_en, rd_en;
    logic pin_low_q_reg;

    // pin function decode from config
    assign pin_en = config_reg[CFG_LVP_BIT] | config_reg[CFG_PINEN_BIT];
    // disabled pin is a plain input; pull-up is software's, enabled pin always pulls up
    assign pin_pullup_en = pin_en ? 1'b1 : config_reg[CFG_PUPSW_BIT];
    assign pin_gpio_in = pin_en ? 1'b0 : pin_s2_reg;

    ////////////////////////////////////////////////////////////////////////
    // glitch filter: the pin must hold a new level FILT_CYC cycles before it counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_cnt_reg <= 3'h0;
            pin_filt_reg <= 1'b1;
        end else if (ext_reset_pin == pin_filt_reg) begin
            filt_cnt_reg <= 3'h0;
        end else if (filt_cnt_reg == 3'(FILT_CYC - 1)) begin
            filt_cnt_reg <= 3'h0;
            pin_filt_reg <= ext_reset_pin;
        end else begin
            filt_cnt_reg <= filt_cnt_reg + 3'h1;
        end
    end

    // two-stage synchroniser for the filtered level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_reg <= 1'b1;
            pin_s2_reg <= 1'b1;
        end else begin
            pin_s1_reg <= pin_filt_reg;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // first cycle of an enabled low level is the pin reset event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_low_q_reg <= 1'b0;
        end else begin
            pin_low_q_reg <= pin_en & ~pin_s2_reg;
        end
    end
    assign pin_low_evt = pin_en & ~pin_s2_reg & ~pin_low_q_reg;

    // programming mode exit counts as a power-on event
    assign power_evt = src.por | src.bor | src.prog_exit;
    assign run_evt = src.wdt_timeout | src.wdt_window | src.reset_instr
                   | (config_reg[CFG_STKEN_BIT] & (src.stack_over | src.stack_under))
                   | src.fetch_bad;

    ////////////////////////////////////////////////////////////////////////
    // power-up delay length from the two-bit select
    always_comb begin
        case (config_reg[CFG_POWER_UP_DELAY_SELECT_LSB +: 2])
            2'b01: power_up_delay_timer_len = 32'(POWER_UP_DELAY_TIMER_1);
            2'b10: power_up_delay_timer_len = 32'(POWER_UP_DELAY_TIMER_2);
            2'b11: power_up_delay_timer_len = 32'(POWER_UP_DELAY_TIMER_3);
            default: power_up_delay_timer_len = 32'h0;
        endcase
    end

    // power timers restart while power is bad; they ignore the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_up_delay_timer_cnt_reg <= 32'h0;
            ost_cnt_reg <= 32'h0;
            power_hold_reg <= 1'b1;
        end else if (src.por | src.bor | src.prog_exit) begin
            power_up_delay_timer_cnt_reg <= 32'h0;
            ost_cnt_reg <= 32'h0;
            power_hold_reg <= 1'b1;
        end else if (power_hold_reg) begin
            if (power_up_delay_timer_cnt_reg < power_up_delay_timer_len) begin
                power_up_delay_timer_cnt_reg <= power_up_delay_timer_cnt_reg + 32'h1;
            end
            if (config_reg[CFG_OSTREQ_BIT] && ost_cnt_reg < 32'(OST_LEN)) begin
                ost_cnt_reg <= ost_cnt_reg + 32'h1;
            end
            if (power_up_delay_timer_cnt_reg >= power_up_delay_timer_len
                && (!config_reg[CFG_OSTREQ_BIT] || ost_cnt_reg >= 32'(OST_LEN))) begin
                power_hold_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer: hold while any reason stays, then RELEASE_OSC_CYCLES before run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_reg <= SEQ_HOLD;
            rel_cnt_reg <= 4'h0;
        end else begin
            case (seq_reg)
                SEQ_RUN: begin
                    if (power_evt || run_evt || pin_low_evt) begin
                        seq_reg <= SEQ_HOLD;
                    end
                end
                SEQ_HOLD: begin
                    rel_cnt_reg <= 4'h0;
                    if (!power_hold_reg && !(pin_en && !pin_s2_reg) && !power_evt) begin
                        seq_reg <= SEQ_RELEASE;
                    end
                end
                SEQ_RELEASE: begin
                    if (power_evt || (pin_en && !pin_s2_reg) || run_evt) begin
                        seq_reg <= SEQ_HOLD;
                    end else if (rel_cnt_reg == 4'(RELEASE_OSC_CYCLES - 1)) begin
                        seq_reg <= SEQ_RUN;
                    end else begin
                        rel_cnt_reg <= rel_cnt_reg + 4'h1;
                    end
                end
                default: seq_reg <= SEQ_HOLD;
            endcase
        end
    end
    assign core_reset = (seq_reg != SEQ_RUN);

    // program counter load value is always zero during reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_load <= 21'h0;
        end else begin
            pc_load <= 21'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb decode: zero wait states, unmapped address answers pslverr
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & (paddr > SEQ_OFF || paddr[1:0] != 2'b00);

    // cause register 0: hardware change wins over a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause0_reg <= CAUSE0_POR_VAL;
        end else begin
            if (wr_en && paddr == CAUSE0_OFF) begin
                cause0_reg <= pwdata[7:0];
            end
            if (src.por | src.prog_exit) begin
                cause0_reg <= CAUSE0_POR_VAL;
            end else if (src.bor) begin
                cause0_reg <= (cause0_reg & ~CAUSE0_BOR_MASK) | CAUSE0_BOR_VAL;
            end else begin
                if (pin_low_evt) cause0_reg[C0_EXT_BIT] <= 1'b0;
                if (src.wdt_timeout) cause0_reg[C0_WTO_BIT] <= 1'b0;
                if (src.wdt_window) cause0_reg[C0_WWIN_BIT] <= 1'b0;
                if (src.reset_instr) cause0_reg[C0_RI_BIT] <= 1'b0;
                if (config_reg[CFG_STKEN_BIT] && src.stack_over) begin
                    cause0_reg[C0_STACK_OVER_FLAG_BIT] <= 1'b1;
                end
                if (config_reg[CFG_STKEN_BIT] && src.stack_under) begin
                    cause0_reg[C0_STACK_UNDER_FLAG_BIT] <= 1'b1;
                end
            end
        end
    end

    // cause register 1: only the violation flag is implemented
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause1_reg <= CAUSE1_POR_VAL;
        end else if (power_evt) begin
            cause1_reg <= CAUSE1_POR_VAL;
        end else if (src.fetch_bad) begin
            cause1_reg[C1_MEM_VIOLATION_FLAG_BIT] <= 1'b0;
        end else if (wr_en && paddr == CAUSE1_OFF) begin
            cause1_reg[C1_MEM_VIOLATION_FLAG_BIT] <= pwdata[C1_MEM_VIOLATION_FLAG_BIT];
        end
    end

    // status register timeout and powerdown bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= STATUS_POR_VAL;
        end else if (power_evt) begin
            status_reg <= STATUS_POR_VAL;
        end else if (src.wdt_timeout) begin
            status_reg[ST_TO_BIT] <= 1'b0;
        end else if (pin_low_evt && in_sleep) begin
            status_reg[ST_TO_BIT] <= 1'b1;
            status_reg[ST_PD_BIT] <= 1'b0;
        end
    end

    // config register: pin enable, lvp, stack enable, protected area, timers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_reg <= CONFIG_RST_VAL;
        end else if (wr_en && paddr == CONFIG_OFF) begin
            config_reg <= pwdata[7:0];
        end
    end

    // scratch command register, readable back
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_reg <= 8'h00;
        end else if (wr_en && paddr == CMD_OFF) begin
            cmd_reg <= pwdata[7:0];
        end
    end

    // read data from flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                CAUSE0_OFF: prdata <= {24'h0, cause0_reg};
                CAUSE1_OFF: prdata <= {24'h0, cause1_reg};
                STATUS_OFF: prdata <= {24'h0, status_reg};
                CONFIG_OFF: prdata <= {24'h0, config_reg};
                CMD_OFF: prdata <= {24'h0, cmd_reg};
                SEQ_OFF: prdata <= {28'h0, power_hold_reg, pin_s2_reg, seq_reg};
                default: prdata <= 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // helper for the filter check: length of the current low run on the pin
    logic [3:0] low_run_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_run_reg <= 4'h0;
        end else if (ext_reset_pin) begin
            low_run_reg <= 4'h0;
        end else if (low_run_reg != 4'hf) begin
            low_run_reg <= low_run_reg + 4'h1; // saturates so a long hold never wraps
        end
    end

    a_pin_decode: assert property (@(posedge pclk) disable iff (!presetn)
        pin_en == (config_reg[0] | config_reg[1])) else $error("pin decode wrong");
    a_pin_holds: assert property (@(posedge pclk) disable iff (!presetn)
        (pin_en && !pin_s2_reg) |=> core_reset) else $error("pin low not held");
    a_pin_filter: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(pin_filt_reg) |-> low_run_reg >= 4'(FILT_CYC)) else $error("short pulse passed");
    a_ext_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (pin_low_evt && !power_evt) |=> !cause0_reg[3]) else $error("ext flag");
    a_wdt_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (src.wdt_timeout && !power_evt) |=> !cause0_reg[4] && !status_reg[6])
        else $error("wdt flag");
    a_window_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (src.wdt_window && !power_evt) |=> !cause0_reg[5] && core_reset)
        else $error("window flag");
    a_sleep_status: assert property (@(posedge pclk) disable iff (!presetn)
        (pin_low_evt && in_sleep && !power_evt && !src.wdt_timeout)
        |=> status_reg[6] && !status_reg[5]) else $error("sleep status");
    a_ri_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (src.reset_instr && !power_evt) |=> !cause0_reg[2]) else $error("ri flag");
    a_stack_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (config_reg[2] && src.stack_over && !power_evt) |=> cause0_reg[7] && core_reset)
        else $error("stack flag");
    a_power_hold: assert property (@(posedge pclk) disable iff (!presetn)
        power_evt |=> power_hold_reg && core_reset) else $error("power hold");
    a_release_wait: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(core_reset)
        |-> $past(seq_reg) == SEQ_RELEASE && $past(seq_reg, 10) == SEQ_RELEASE)
        else $error("release too soon");
    a_mem_violation_flag_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (src.fetch_bad && !power_evt) |=> !cause1_reg[1] ##1 core_reset)
        else $error("mem_violation_flag flag");
    a_por_load: assert property (@(posedge pclk) disable iff (!presetn)
        src.por |=> cause0_reg == 8'h3c && core_reset) else $error("por load");
    a_bor_load: assert property (@(posedge pclk) disable iff (!presetn)
        (src.bor && !src.por && !src.prog_exit)
        |=> cause0_reg[7:2] == 6'h0f && !cause0_reg[0] && cause1_reg[1])
        else $error("bor load");
    a_sw_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == CAUSE0_OFF && !core_reset && !power_evt && !run_evt && !pin_low_evt)
        |=> !core_reset) else $error("flag write reset");
endmodule

// >>> shared/rsc_pkg.sv
// package for the reset source and cause block: offsets, fields, reset values, types
package rsc_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] CAUSE0_OFF = 8'h00;
    localparam logic [7:0] CAUSE1_OFF = 8'h04;
    localparam logic [7:0] STATUS_OFF = 8'h08;
    localparam logic [7:0] CONFIG_OFF = 8'h0c;
    localparam logic [7:0] CMD_OFF = 8'h10;
    localparam logic [7:0] SEQ_OFF = 8'h14;
    // cause register 0 bit positions
    localparam int C0_STACK_OVER_FLAG_BIT = 7;
    localparam int C0_STACK_UNDER_FLAG_BIT = 6;
    localparam int C0_WWIN_BIT = 5;
    localparam int C0_WTO_BIT = 4;
    localparam int C0_EXT_BIT = 3;
    localparam int C0_RI_BIT = 2;
    localparam int C0_POR_BIT = 1;
    localparam int C0_BOR_BIT = 0;
    // cause register 1 and status bit positions
    localparam int C1_MEM_VIOLATION_FLAG_BIT = 1;
    localparam int ST_TO_BIT = 6;
    localparam int ST_PD_BIT = 5;
    // values loaded on power-on and brown-out (unknown bit taken as 0)
    localparam logic [7:0] CAUSE0_POR_VAL = 8'h3c;
    localparam logic [7:0] CAUSE0_BOR_MASK = 8'hfd;
    localparam logic [7:0] CAUSE0_BOR_VAL = 8'h3c;
    localparam logic [7:0] CAUSE1_POR_VAL = 8'h02;
    localparam logic [7:0] STATUS_POR_VAL = 8'h60;
    // config register field positions
    localparam int CFG_LVP_BIT = 0;
    localparam int CFG_PINEN_BIT = 1;
    localparam int CFG_STKEN_BIT = 2;
    localparam int CFG_SAFEN_BIT = 3;
    localparam int CFG_OSTREQ_BIT = 4;
    localparam int CFG_PUPSW_BIT = 5;
    localparam int CFG_POWER_UP_DELAY_SELECT_LSB = 6;
    localparam logic [7:0] CONFIG_RST_VAL = 8'h02;
    // timing
    localparam int CLK_MHZ = 100;
    localparam int RELEASE_OSC_CYCLES = 10;
    localparam int POWER_UP_DELAY_TIMER_1_US = 1000;
    localparam int POWER_UP_DELAY_TIMER_2_US = 16000;
    localparam int POWER_UP_DELAY_TIMER_3_US = 64000;
    localparam int POWER_UP_DELAY_TIMER_1_CYC = POWER_UP_DELAY_TIMER_1_US * CLK_MHZ;
    localparam int POWER_UP_DELAY_TIMER_2_CYC = POWER_UP_DELAY_TIMER_2_US * CLK_MHZ;
    localparam int POWER_UP_DELAY_TIMER_3_CYC = POWER_UP_DELAY_TIMER_3_US * CLK_MHZ;
    localparam int OST_CYC = 1024;
    localparam int FILT_CYC = 8;
    // reset sequencer states
    typedef enum logic [1:0] {SEQ_RUN, SEQ_HOLD, SEQ_RELEASE} rsc_seq_type;
    // reset sources as one bundle
    typedef struct packed {
        logic por;
        logic bor;
        logic prog_exit;
        logic wdt_timeout;
        logic wdt_window;
        logic reset_instr;
        logic stack_over;
        logic stack_under;
        logic fetch_bad;
    } rsc_src_type;
endpackage
